// [pkg/ffp_defines.svh]
`ifndef FFP_DEFINES_SVH
`define FFP_DEFINES_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define FFP_IDX_CFG        4'h4
`define FFP_IDX_IRQCFG     4'h5
`define FFP_IDX_STAT       4'h6
`define FFP_IDX_ERR        4'h7
`define FFP_IDX_PROT       4'h8

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FFP_CFG_IGNORE_SF  0
`define FFP_IRQCFG_SF_EN   0
`define FFP_STAT_VIOL      4
`define FFP_ERR_DF         1
`define FFP_ERR_SF         0
`define FFP_PROT_OPEN      7
`define FFP_PROT_RNV       6
`define FFP_PROT_HDIS      5
`define FFP_PROT_HS_HI     4
`define FFP_PROT_HS_LO     3
`define FFP_PROT_LDIS      2
`define FFP_PROT_LS_HI     1
`define FFP_PROT_LS_LO     0

// ----------------------------------------
// Reset values and constants
// ----------------------------------------
`define FFP_PROT_FULL      8'h7F
`define FFP_CFG_RESET      8'h00
`define FFP_PROT_BYTE_ADDR 24'hFF_FE0C
`define FFP_HIGH_LAST      24'hFF_FFFF
`define FFP_HIGH_MIN_SIZE  24'h00_0800
`define FFP_LOW_BASE       24'hFF_8000
`define FFP_LOW_MIN_SIZE   24'h00_0400
`define FFP_SCEN_TRANS     64'hFF_5A_3C_18_08_0C_0A_0F
`define FFP_RESP_OKAY      2'h0
`define FFP_RESP_SLVERR    2'h2

`endif

// [pkg/ffp_pkg.sv]
package ffp_pkg;
    typedef logic [7:0]  ffp_byte_t;
    typedef logic [2:0]  ffp_scen_t;
    typedef logic [1:0]  ffp_resp_t;
    typedef logic [23:0] ffp_gaddr_t;
endpackage : ffp_pkg

// [rtl/ffp_range_check.sv]
`timescale 1ns/100ps
`include "ffp_defines.svh"

module ffp_range_check (
    input  wire ffp_pkg::ffp_byte_t  prot,         // Current protection byte
    input  wire ffp_pkg::ffp_gaddr_t addr,         // Global target address
    output logic                     addrProtected, // Target lies in protected area
    output logic                     anyProtected   // Some sector is protected
);

    // ----------------------------------------
    // Range bounds
    // ----------------------------------------
    wire [1:0]               hiSel  = prot[`FFP_PROT_HS_HI:`FFP_PROT_HS_LO];
    wire [1:0]               loSel  = prot[`FFP_PROT_LS_HI:`FFP_PROT_LS_LO];
    wire ffp_pkg::ffp_gaddr_t hiSize = `FFP_HIGH_MIN_SIZE << hiSel;
    wire ffp_pkg::ffp_gaddr_t loSize = `FFP_LOW_MIN_SIZE << loSel;
    wire ffp_pkg::ffp_gaddr_t hiBase = 24'(`FFP_HIGH_LAST - hiSize + 24'h00_0001);
    wire ffp_pkg::ffp_gaddr_t loLast = 24'(`FFP_LOW_BASE + loSize - 24'h00_0001);

    wire inHigh = (addr >= hiBase);
    wire inLow  = (addr >= `FFP_LOW_BASE) && (addr <= loLast);
    wire hitRng = (!prot[`FFP_PROT_HDIS] && inHigh) || (!prot[`FFP_PROT_LDIS] && inLow);

    // ----------------------------------------
    // Open bit selects protect or unprotect
    // ----------------------------------------
    assign addrProtected = prot[`FFP_PROT_OPEN] ? hitRng : !hitRng;
    assign anyProtected  = !(prot[`FFP_PROT_OPEN] && prot[`FFP_PROT_HDIS]
                             && prot[`FFP_PROT_LDIS]);

endmodule : ffp_range_check

// [rtl/ffp_axil_port.sv]
`timescale 1ns/100ps
`include "ffp_defines.svh"

module ffp_axil_port #(
    parameter int AW = 8
) (
    input  wire logic          mclk,    // System clock
    input  wire logic          resetn,  // Sync reset, active low
    input  wire logic          awvalid, // Write address valid
    output logic               awready, // Write address ready
    input  wire logic [AW-1:0] awaddr,  // Write address
    input  wire logic          wvalid,  // Write data valid
    output logic               wready,  // Write data ready
    input  wire logic [31:0]   wdata,   // Write data
    input  wire logic [3:0]    wstrb,   // Write strobes
    output logic               bvalid,  // Write response valid
    input  wire logic          bready,  // Write response ready
    output ffp_pkg::ffp_resp_t bresp,   // Write response
    input  wire logic          arvalid, // Read address valid
    output logic               arready, // Read address ready
    input  wire logic [AW-1:0] araddr,  // Read address
    output logic               rvalid,  // Read data valid
    input  wire logic          rready,  // Read data ready
    output logic [31:0]        rdata,   // Read data
    output ffp_pkg::ffp_resp_t rresp,   // Read response
    output logic               wrReq,   // Write strobe to registers
    output logic [AW-1:0]      wrAddr,  // Write address to registers
    output logic [31:0]        wrData,  // Write data to registers
    output logic [3:0]         wrStrb,  // Write strobes to registers
    input  wire logic          wrOk,    // Write address is mapped
    output logic               rdReq,   // Read strobe to registers
    output logic [AW-1:0]      rdAddr,  // Read address to registers
    input  wire logic [31:0]   rdData,  // Read data from registers
    input  wire logic          rdOk     // Read address is mapped
);

    logic          awHeld_q;
    logic [AW-1:0] awAddr_q;
    logic          wHeld_q;
    logic [31:0]   wData_q;
    logic [3:0]    wStrb_q;

    // ----------------------------------------
    // Channel acceptance
    // ----------------------------------------
    assign awready = !awHeld_q && !bvalid;
    assign wready  = !wHeld_q && !bvalid;
    assign arready = !rvalid;

    wire awTake = awvalid && awready;
    wire wTake  = wvalid && wready;

    assign wrReq  = (awHeld_q || awTake) && (wHeld_q || wTake);
    assign wrAddr = awHeld_q ? awAddr_q : awaddr;
    assign wrData = wHeld_q ? wData_q : wdata;
    assign wrStrb = wHeld_q ? wStrb_q : wstrb;
    assign rdReq  = arvalid && arready;
    assign rdAddr = araddr;

    // ----------------------------------------
    // Write side
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            awHeld_q <= 1'b0;
            awAddr_q <= '0;
            wHeld_q  <= 1'b0;
            wData_q  <= 32'h0000_0000;
            wStrb_q  <= 4'h0;
        end else begin
            awHeld_q <= !wrReq && (awHeld_q || awTake);
            wHeld_q  <= !wrReq && (wHeld_q || wTake);
            if (awTake) awAddr_q <= awaddr;
            if (wTake) wData_q <= wdata;
            if (wTake) wStrb_q <= wstrb;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            bvalid <= 1'b0;
            bresp  <= `FFP_RESP_OKAY;
        end else if (wrReq) begin
            bvalid <= 1'b1;
            bresp  <= wrOk ? `FFP_RESP_OKAY : `FFP_RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // Read side
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= `FFP_RESP_OKAY;
        end else if (rdReq) begin
            rvalid <= 1'b1;
            rdata  <= rdOk ? rdData : 32'h0000_0000;
            rresp  <= rdOk ? `FFP_RESP_OKAY : `FFP_RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

endmodule : ffp_axil_port

// [rtl/ffp_flash_prot.sv]
// Summary of operation
// - Double fault or busy read sets bit 1
// - Double flag clears only by writing one
// - Single fault or busy read sets bit 0 unless CFG ignore bit is set
// - Single flag clears only by writing one
// - Fault flags stored two clocks after read
// - Normal mode writes may only add protection
// - Special mode writes protection bits freely
// - Protection byte loaded during reset sequence
// - Double fault on load gives full protection
// - Protected program or erase refused, violation set
// - Block erase refused if any sector protected
// - Open bit selects protect or unprotect ranges
// - High range disable bit, range ends top
// - High size writable only while high disabled
// - Low size writable only while low disabled
// - Disallowed scenario write ignored entirely
// - Single flag with enable requests interrupt
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "ffp_defines.svh"

module ffp_flash_prot #(
    parameter int AXI_ADDR_W = 8
) (
    input  wire logic                  mclk,           // System clock
    input  wire logic                  resetn,         // Sync reset, active low
    input  wire logic                  s_axi_awvalid,  // Write address valid
    output logic                       s_axi_awready,  // Write address ready
    input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,   // Write address
    input  wire logic                  s_axi_wvalid,   // Write data valid
    output logic                       s_axi_wready,   // Write data ready
    input  wire logic [31:0]           s_axi_wdata,    // Write data
    input  wire logic [3:0]            s_axi_wstrb,    // Write strobes
    output logic                       s_axi_bvalid,   // Write response valid
    input  wire logic                  s_axi_bready,   // Write response ready
    output ffp_pkg::ffp_resp_t         s_axi_bresp,    // Write response
    input  wire logic                  s_axi_arvalid,  // Read address valid
    output logic                       s_axi_arready,  // Read address ready
    input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,   // Read address
    output logic                       s_axi_rvalid,   // Read data valid
    input  wire logic                  s_axi_rready,   // Read data ready
    output logic [31:0]                s_axi_rdata,    // Read data
    output ffp_pkg::ffp_resp_t         s_axi_rresp,    // Read response
    input  wire logic                  specialMode,    // Special single-chip mode
    input  wire logic                  cfgLoad,        // Protection byte fetched
    input  wire ffp_pkg::ffp_byte_t    cfgByte,        // Fetched protection byte
    input  wire logic                  cfgDoubleFault, // Fetch had double fault
    input  wire logic                  rdDone,         // Array read finished
    input  wire logic                  eccSingle,      // Corrected one-bit error
    input  wire logic                  eccDouble,      // Two-bit error
    input  wire logic                  rdBusyBlock,    // Read hit busy block
    input  wire logic                  cmdValid,       // Program or erase request
    input  wire logic                  cmdBlockErase,  // Request is block erase
    input  wire ffp_pkg::ffp_gaddr_t   cmdAddr,        // Request target address
    output logic                       cmdAccept,      // Request allowed, pulse
    output logic                       cmdRefused,     // Request refused, pulse
    output ffp_pkg::ffp_byte_t         protByte,       // Active protection byte
    output logic                       doubleFault,    // Double fault flag
    output logic                       singleFault,    // Single fault flag
    output logic                       singleFaultIrq  // Single fault interrupt
);

    // ----------------------------------------
    // Elaboration check
    // ----------------------------------------
    if (AXI_ADDR_W < 6) begin : g_bad_aw
        $error("AXI_ADDR_W too small for register map");
    end

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    function automatic logic isReg(input logic [AXI_ADDR_W-1:0] a,
                                   input logic [3:0] idx);
        isReg = (a[AXI_ADDR_W-1:2] == (AXI_ADDR_W-2)'(idx));
    endfunction : isReg

    function automatic logic transOk(input ffp_pkg::ffp_scen_t from,
                                     input ffp_pkg::ffp_scen_t to);
        logic [63:0] tbl;
        tbl     = `FFP_SCEN_TRANS;
        transOk = tbl[{from, to}];
    endfunction : transOk

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic               doubleFault_q;
    logic               singleFault_q;
    logic               ignoreSf_q;
    logic               sfIrqEn_q;
    logic               protViol_q;
    ffp_pkg::ffp_byte_t prot_q;
    logic               rdDone_q;
    logic               eccSingle_q;
    logic               eccDouble_q;
    logic               rdBusy_q;
    logic               cmdAccept_q;
    logic               cmdRefused_q;

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    logic                  wrReq;
    logic [AXI_ADDR_W-1:0] wrAddr;
    logic [31:0]           wrData;
    logic [3:0]            wrStrb;
    logic                  rdReq;
    logic [AXI_ADDR_W-1:0] rdAddr;
    logic [31:0]           rdData;
    logic                  wrOk;
    logic                  rdOk;

    ffp_axil_port #(
        .AW      (AXI_ADDR_W)
    ) u_port (
        .mclk    (mclk),
        .resetn  (resetn),
        .awvalid (s_axi_awvalid),
        .awready (s_axi_awready),
        .awaddr  (s_axi_awaddr),
        .wvalid  (s_axi_wvalid),
        .wready  (s_axi_wready),
        .wdata   (s_axi_wdata),
        .wstrb   (s_axi_wstrb),
        .bvalid  (s_axi_bvalid),
        .bready  (s_axi_bready),
        .bresp   (s_axi_bresp),
        .arvalid (s_axi_arvalid),
        .arready (s_axi_arready),
        .araddr  (s_axi_araddr),
        .rvalid  (s_axi_rvalid),
        .rready  (s_axi_rready),
        .rdata   (s_axi_rdata),
        .rresp   (s_axi_rresp),
        .wrReq   (wrReq),
        .wrAddr  (wrAddr),
        .wrData  (wrData),
        .wrStrb  (wrStrb),
        .wrOk    (wrOk),
        .rdReq   (rdReq),
        .rdAddr  (rdAddr),
        .rdData  (rdData),
        .rdOk    (rdOk)
    );

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    wire wCfg  = isReg(wrAddr, `FFP_IDX_CFG);
    wire wIrq  = isReg(wrAddr, `FFP_IDX_IRQCFG);
    wire wStat = isReg(wrAddr, `FFP_IDX_STAT);
    wire wErr  = isReg(wrAddr, `FFP_IDX_ERR);
    wire wProt = isReg(wrAddr, `FFP_IDX_PROT);
    wire rCfg  = isReg(rdAddr, `FFP_IDX_CFG);
    wire rIrq  = isReg(rdAddr, `FFP_IDX_IRQCFG);
    wire rStat = isReg(rdAddr, `FFP_IDX_STAT);
    wire rErr  = isReg(rdAddr, `FFP_IDX_ERR);
    wire rProt = isReg(rdAddr, `FFP_IDX_PROT);

    assign wrOk = wCfg || wIrq || wStat || wErr || wProt;
    assign rdOk = rCfg || rIrq || rStat || rErr || rProt;

    wire wrLow  = wrReq && wrStrb[0];
    wire wrCfg  = wrLow && wCfg;
    wire wrIrq  = wrLow && wIrq;
    wire wrStat = wrLow && wStat;
    wire wrErr  = wrLow && wErr;
    wire wrProt = wrLow && wProt;

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    wire [7:0] cfgRd  = 8'(ignoreSf_q) << `FFP_CFG_IGNORE_SF;
    wire [7:0] irqRd  = 8'(sfIrqEn_q) << `FFP_IRQCFG_SF_EN;
    wire [7:0] statRd = 8'(protViol_q) << `FFP_STAT_VIOL;
    wire [7:0] errRd  = (8'(doubleFault_q) << `FFP_ERR_DF)
                      | (8'(singleFault_q) << `FFP_ERR_SF);
    wire [7:0] rdByte = rCfg  ? cfgRd  :
                        rIrq  ? irqRd  :
                        rStat ? statRd :
                        rErr  ? errRd  :
                        rProt ? prot_q : 8'h00;

    assign rdData = {24'h00_0000, rdByte};

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ignoreSf_q <= 1'b0;
            sfIrqEn_q  <= 1'b0;
        end else begin
            if (wrCfg) ignoreSf_q <= wrData[`FFP_CFG_IGNORE_SF];
            if (wrIrq) sfIrqEn_q <= wrData[`FFP_IRQCFG_SF_EN];
        end
    end

    // ----------------------------------------
    // ECC fault capture
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            rdDone_q    <= 1'b0;
            eccSingle_q <= 1'b0;
            eccDouble_q <= 1'b0;
            rdBusy_q    <= 1'b0;
        end else begin
            rdDone_q    <= rdDone;
            eccSingle_q <= eccSingle;
            eccDouble_q <= eccDouble;
            rdBusy_q    <= rdBusyBlock;
        end
    end

    wire dfSet = rdDone_q && (eccDouble_q || rdBusy_q);
    wire sfSet = rdDone_q && !ignoreSf_q && (eccSingle_q || rdBusy_q);
    wire dfClr = wrErr && wrData[`FFP_ERR_DF];
    wire sfClr = wrErr && wrData[`FFP_ERR_SF];

    // Set wins over a clear in the same cycle
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            doubleFault_q <= 1'b0;
            singleFault_q <= 1'b0;
        end else begin
            doubleFault_q <= dfSet || (doubleFault_q && !dfClr);
            singleFault_q <= sfSet || (singleFault_q && !sfClr);
        end
    end

    assign doubleFault    = doubleFault_q;
    assign singleFault    = singleFault_q;
    assign singleFaultIrq = singleFault_q && sfIrqEn_q;

    // ----------------------------------------
    // Protection write filter
    // ----------------------------------------
    wire ffp_pkg::ffp_scen_t curScen = {prot_q[`FFP_PROT_OPEN],
                                        prot_q[`FFP_PROT_HDIS],
                                        prot_q[`FFP_PROT_LDIS]};
    wire ffp_pkg::ffp_scen_t reqScen = {wrData[`FFP_PROT_OPEN],
                                        wrData[`FFP_PROT_HDIS],
                                        wrData[`FFP_PROT_LDIS]};

    wire scenOk = specialMode || transOk(curScen, reqScen);
    wire hsOpen = specialMode || prot_q[`FFP_PROT_HDIS];
    wire lsOpen = specialMode || prot_q[`FFP_PROT_LDIS];

    wire [1:0] newHs = hsOpen ? wrData[`FFP_PROT_HS_HI:`FFP_PROT_HS_LO]
                              : prot_q[`FFP_PROT_HS_HI:`FFP_PROT_HS_LO];
    wire [1:0] newLs = lsOpen ? wrData[`FFP_PROT_LS_HI:`FFP_PROT_LS_LO]
                              : prot_q[`FFP_PROT_LS_HI:`FFP_PROT_LS_LO];

    // Reserved nonvolatile bit keeps its loaded value
    wire ffp_pkg::ffp_byte_t newProt = {reqScen[2], prot_q[`FFP_PROT_RNV],
                                        reqScen[1], newHs,
                                        reqScen[0], newLs};

    // ----------------------------------------
    // Protection register
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            prot_q <= `FFP_PROT_FULL;
        end else if (cfgLoad) begin
            prot_q <= cfgDoubleFault ? `FFP_PROT_FULL : cfgByte;
        end else if (wrProt && scenOk) begin
            prot_q <= newProt;
        end
    end

    assign protByte = prot_q;

    // ----------------------------------------
    // Program and erase screening
    // ----------------------------------------
    logic addrProt;
    logic anyProt;

    ffp_range_check u_range (
        .prot          (prot_q),
        .addr          (cmdAddr),
        .addrProtected (addrProt),
        .anyProtected  (anyProt)
    );

    wire cmdBad = cmdBlockErase ? anyProt : addrProt;
    wire violSet = cmdValid && cmdBad;
    wire violClr = wrStat && wrData[`FFP_STAT_VIOL];

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            protViol_q   <= 1'b0;
            cmdAccept_q  <= 1'b0;
            cmdRefused_q <= 1'b0;
        end else begin
            protViol_q   <= violSet || (protViol_q && !violClr);
            cmdAccept_q  <= cmdValid && !cmdBad;
            cmdRefused_q <= violSet;
        end
    end

    assign cmdAccept  = cmdAccept_q;
    assign cmdRefused = cmdRefused_q;

endmodule : ffp_flash_prot

// [sim/ffp_checker.sv]
`timescale 1ns/100ps
module ffp_checker (
    input wire logic               mclk,           // Clock
    input wire logic               resetn,         // Reset, active low
    input wire logic               s_axi_bvalid,   // Write answer
    input wire logic               cfgLoad,        // Byte fetched
    input wire ffp_pkg::ffp_byte_t cfgByte,        // Fetched byte
    input wire logic               cfgDoubleFault, // Fetch fault
    input wire logic               rdDone,         // Read done
    input wire logic               eccDouble,      // Two-bit error
    input wire logic               rdBusyBlock,    // Busy read
    input wire logic               cmdValid,       // Command
    input wire logic               cmdBlockErase,  // Block erase
    input wire logic               cmdAccept,      // Allowed
    input wire logic               cmdRefused,     // Refused
    input wire ffp_pkg::ffp_byte_t protByte,       // Protection
    input wire logic               doubleFault,    // Double flag
    input wire logic               singleFault     // Single flag
);
    // ----------------------------------------
    // Flag, command and protection timing
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    AST_DF_SET: assert property (rdDone && (eccDouble || rdBusyBlock) |-> ##[1:3] doubleFault)
        else $error("double flag missed");
    AST_DF_CLR: assert property ($fell(doubleFault) |-> $rose(s_axi_bvalid))
        else $error("double flag lost");
    AST_SF_SET: assert property ($rose(singleFault) |-> $past(rdDone) || $past(rdDone, 2) ||
        $past(rdDone, 3)) else $error("single flag unprompted");
    AST_SF_CLR: assert property ($fell(singleFault) |-> $rose(s_axi_bvalid))
        else $error("single flag lost");
    AST_CMD: assert property (cmdValid |=> cmdAccept != cmdRefused)
        else $error("command answer wrong");
    AST_BLK: assert property (cmdValid && cmdBlockErase &&
        !(protByte[7] && protByte[5] && protByte[2]) |=> cmdRefused) else $error("erase let through");
    AST_LOAD_DF: assert property (cfgLoad && cfgDoubleFault |=> protByte == 8'h7F)
        else $error("fault load not full");
    AST_LOAD: assert property (cfgLoad && !cfgDoubleFault |=> protByte == $past(cfgByte))
        else $error("load wrong");
    AST_PROT: assert property ($changed(protByte) |-> $past(cfgLoad) || $rose(s_axi_bvalid))
        else $error("protection changed alone");
endmodule : ffp_checker

// [sim/test_flash_error_status_and_protection.sv]
`timescale 1ns/100ps
`include "ffp_defines.svh"
module test_flash_error_status_and_protection;
    logic       mclk = 0, resetn = 0, specialMode = 0, cfgLoad = 0, cfgDoubleFault = 0;
    logic       s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0, s_axi_bready = 1;
    logic       s_axi_rready = 1, rdDone = 0, eccSingle = 0, eccDouble = 0, rdBusyBlock = 0;
    logic       cmdValid = 0, cmdBlockErase = 0, cmdAccept, cmdRefused, singleFaultIrq;
    logic       s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic       doubleFault, singleFault;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [63:0] trans = `FFP_SCEN_TRANS;
    ffp_pkg::ffp_byte_t cfgByte = 8'h00, protByte, b;
    ffp_pkg::ffp_gaddr_t cmdAddr = 24'h0;
    ffp_pkg::ffp_resp_t s_axi_bresp, s_axi_rresp;
    int         n_errors = 0, samples_checked = 0, f, t;

    ffp_flash_prot ffp_flash_prot_inst (
        .mclk, .resetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
        .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
        .s_axi_rdata, .s_axi_rresp, .specialMode, .cfgLoad, .cfgByte, .cfgDoubleFault, .rdDone,
        .eccSingle, .eccDouble, .rdBusyBlock, .cmdValid, .cmdBlockErase, .cmdAddr, .cmdAccept,
        .cmdRefused, .protByte, .doubleFault, .singleFault, .singleFaultIrq
    );
    always #5 mclk = ~mclk;
    // ----------------------------------------
    // Bus and sideband tasks
    // ----------------------------------------
    task automatic ck(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : ck
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
        do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
        ck("bresp", er, s_axi_bresp);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        do @(posedge mclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 0;
        do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
        ck("rdata", e, s_axi_rdata);
        ck("rresp", er, s_axi_rresp);
    endtask : rd
    task automatic load(input ffp_pkg::ffp_byte_t v, input logic df, input ffp_pkg::ffp_byte_t e);
        cfgByte <= v;
        cfgDoubleFault <= df;
        cfgLoad <= 1;
        @(posedge mclk);
        cfgLoad <= 0;
        @(posedge mclk);
        ck("protByte", e, protByte);
    endtask : load
    task automatic ecc(input logic s, input logic d, input logic busy, input logic [31:0] e);
        rdDone <= 1;
        eccSingle <= s;
        eccDouble <= d;
        rdBusyBlock <= busy;
        @(posedge mclk);
        rdDone <= 0;
        repeat (3) @(posedge mclk);
        rd(8'h1C, e);
    endtask : ecc
    task automatic cmd(input ffp_pkg::ffp_gaddr_t a, input logic blk, input logic r);
        cmdAddr <= a;
        cmdBlockErase <= blk;
        cmdValid <= 1;
        @(posedge mclk);
        cmdValid <= 0;
        @(posedge mclk);
        ck("refused", r, cmdRefused);
        ck("accept", !r, cmdAccept);
    endtask : cmd
    function automatic ffp_pkg::ffp_byte_t pb(input logic [2:0] s);
        return {s[2], 1'h1, s[1], 2'h0, s[0], 2'h0};
    endfunction : pb
    task automatic give_verdict;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        #200000;
        n_errors++;
        give_verdict();
    end
    initial begin
        repeat (4) @(posedge mclk);
        resetn <= 1;
        @(posedge mclk);
        ck("protReset", 8'h7F, protByte);
        load(8'h3C, 0, 8'h3C);
        load(8'h3C, 1, 8'h7F);
        for (f = 0; f < 8; f++) begin
            for (t = 0; t < 8; t++) begin
                specialMode <= 1;
                wr(8'h20, {24'h0, pb(f[2:0])});
                specialMode <= 0;
                wr(8'h20, {24'h0, pb(t[2:0])});
                b = trans[f * 8 + t] ? pb(t[2:0]) : pb(f[2:0]);
                rd(8'h20, {24'h0, b});
            end
        end
        specialMode <= 1;
        wr(8'h20, 32'hA4);
        specialMode <= 0;
        wr(8'h20, 32'h8C);
        wr(8'h20, 32'h94);
        rd(8'h20, 32'hCC);
        cmd(24'hFF_F000, 0, 1);
        cmd(24'hFF_EFFF, 0, 0);
        cmd(24'hFF_8000, 1, 1);
        rd(8'h18, 32'h10);
        wr(8'h18, 32'h10);
        rd(8'h18, 32'h0);
        specialMode <= 1;
        wr(8'h20, 32'h0C);
        cmd(24'hFF_F000, 0, 0);
        cmd(24'hFF_EFFF, 0, 1);
        wr(8'h20, 32'hA4);
        cmd(24'hFF_8000, 1, 0);
        wr(8'h14, 32'h1);
        ecc(1, 0, 0, 32'h1);
        ck("irq", 1, singleFaultIrq);
        wr(8'h14, 32'h0);
        ck("irqMasked", 0, singleFaultIrq);
        wr(8'h14, 32'h1);
        wr(8'h1C, 32'h0);
        rd(8'h1C, 32'h1);
        wr(8'h1C, 32'hFF);
        rd(8'h1C, 32'h0);
        ecc(0, 1, 0, 32'h2);
        wr(8'h1C, 32'h0);
        rd(8'h1C, 32'h2);
        wr(8'h1C, 32'h2);
        rd(8'h1C, 32'h0);
        wr(8'h10, 32'h1);
        ecc(1, 0, 1, 32'h2);
        wr(8'h1C, 32'h3);
        wr(8'h3C, 32'h0, 2'h2);
        rd(8'h3C, 32'h0, 2'h2);
        give_verdict();
    end
endmodule : test_flash_error_status_and_protection
bind ffp_flash_prot ffp_checker ffp_checker_inst (.mclk, .resetn, .s_axi_bvalid, .cfgLoad,
    .cfgByte, .cfgDoubleFault, .rdDone, .eccDouble, .rdBusyBlock, .cmdValid, .cmdBlockErase,
    .cmdAccept, .cmdRefused, .protByte, .doubleFault, .singleFault);
